// file: common/drm_pkg.sv
/*
  Constants for the DMA request routing matrix: register offsets, field
  positions, reset values and channel state codes.
  Assumes a 32-bit AHB-Lite slave port and four DMA channels.
*/
`default_nettype none
package drm_pkg;
  localparam int DRM_CHANNELS = 4;
  localparam int DRM_REQS = 16;
  localparam int DRM_SEL_W = 4;
  // Register byte offsets
  localparam logic [11:0] DRM_ROUTE_OFF = 12'h000;
  localparam logic [11:0] DRM_ENABLE_OFF = 12'h004;
  localparam logic [11:0] DRM_STATUS_OFF = 12'h008;
  // Per-channel field layout of the routing register, channel n shifted down by 8n
  localparam int DRM_CH_STRIDE = 8;
  localparam int DRM_CLR_BIT = 31;
  localparam int DRM_SEL_LSB = 24;
  // Reset values
  localparam logic [31:0] DRM_ROUTE_RST = 32'h0000_0000;
  localparam logic [3:0] DRM_ENABLE_RST = 4'h0;
  // One-hot channel states
  typedef enum logic [2:0] {
    DRM_IDLE = 3'b001,
    DRM_BUSY = 3'b010,
    DRM_ACK = 3'b100
  } drm_state_e;
endpackage
`default_nettype wire

// file: verilog/drm_chan.sv
/*
  One DMA channel's request state machine: idle, busy, acknowledge.
  Assumes the selected request and the engine's done pulse are synchronous to mclk.
*/
`default_nettype none
module drm_chan (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fsm_clear,
  input wire logic request_enable,
  input wire logic selected_request,
  input wire logic engine_done,
  output logic start_q,
  output logic ack_q,
  output logic idle_q
);
  import drm_pkg::*;

  drm_state_e state_q;
  drm_state_e state_d;
  wire logic go;

  assign go = (state_q == DRM_IDLE) && request_enable && selected_request;

  always_comb begin
    case (state_q)
      DRM_IDLE: state_d = go ? DRM_BUSY : DRM_IDLE;
      DRM_BUSY: state_d = engine_done ? DRM_ACK : DRM_BUSY;
      DRM_ACK: state_d = DRM_IDLE;
      default: state_d = DRM_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= DRM_IDLE;
      start_q <= 1'b0;
      ack_q <= 1'b0;
      idle_q <= 1'b1;
    end else if (fsm_clear) begin
      // Clear wins over any start or done in the same cycle
      state_q <= DRM_IDLE;
      start_q <= 1'b0;
      ack_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      state_q <= state_d;
      start_q <= go;
      ack_q <= (state_q == DRM_BUSY) && engine_done;
      idle_q <= (state_d == DRM_IDLE);
    end
  end
endmodule
`default_nettype wire

// file: verilog/drm_top.sv
/*
  DMA request routing matrix with AHB-Lite register slave.
  Assumes peripherals drive request levels synchronous to mclk and each channel
  engine pulses its done input once per finished hardware transfer.
*/
// Design decision made here: the AHB-Lite slave port.
`default_nettype none
module drm_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] peripheral_dma_request_ch0,
  input wire logic [15:0] peripheral_dma_request_ch1,
  input wire logic [15:0] peripheral_dma_request_ch2,
  input wire logic [15:0] peripheral_dma_request_ch3,
  input wire logic [3:0] engine_done,
  output logic [15:0] peripheral_dma_ack_ch0,
  output logic [15:0] peripheral_dma_ack_ch1,
  output logic [15:0] peripheral_dma_ack_ch2,
  output logic [15:0] peripheral_dma_ack_ch3,
  output logic [3:0] channel_start,
  output logic [3:0] channel_idle
);
  import drm_pkg::*;

  function automatic logic [3:0] sel_of(input logic [31:0] route, input int ch);
    sel_of = route[DRM_SEL_LSB - ch * DRM_CH_STRIDE +: DRM_SEL_W];
  endfunction

  function automatic logic [15:0] one_hot(input logic [3:0] idx);
    one_hot = 16'h0001 << idx;
  endfunction

  // Register state
  logic [31:0] route_q;
  logic [3:0] peripheral_request_enable_q;
  // Bus data phase state
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic hreadyout_q;
  logic [15:0] ack_q [DRM_CHANNELS];

  wire logic [15:0] req_in [DRM_CHANNELS];
  wire logic [3:0] sel [DRM_CHANNELS];
  wire logic [3:0] selected_req;
  wire logic [3:0] fsm_clear;
  wire logic [3:0] ch_start;
  wire logic [3:0] ch_ack;
  wire logic [3:0] ch_idle;
  wire logic addr_ok;
  wire logic rd_go;
  wire logic wr_go;
  wire logic route_wr;
  wire logic enable_wr;
  wire logic [31:0] route_wdata;
  wire logic [31:0] route_rd;
  wire logic [31:0] rd_mux;
  wire logic [11:0] a_off;

  assign req_in[0] = peripheral_dma_request_ch0;
  assign req_in[1] = peripheral_dma_request_ch1;
  assign req_in[2] = peripheral_dma_request_ch2;
  assign req_in[3] = peripheral_dma_request_ch3;

  // Address phase decode
  assign a_off = haddr[11:0];
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_go = addr_ok && !hwrite;
  assign wr_go = addr_ok && hwrite;

  // Data phase write decode
  assign route_wr = wr_pend_q && (wr_addr_q == DRM_ROUTE_OFF);
  assign enable_wr = wr_pend_q && (wr_addr_q == DRM_ENABLE_OFF);

  // Only the selector fields are stored; clear and reserved bits are dropped
  genvar g;
  generate
    for (g = 0; g < DRM_CHANNELS; g++) begin : g_ch
      localparam int SL = DRM_SEL_LSB - g * DRM_CH_STRIDE;
      localparam int CB = DRM_CLR_BIT - g * DRM_CH_STRIDE;
      assign route_wdata[SL + DRM_SEL_W +: DRM_CH_STRIDE - DRM_SEL_W] = '0;
      assign route_wdata[SL +: DRM_SEL_W] = hwdata[SL +: DRM_SEL_W];
      assign fsm_clear[g] = route_wr && hwdata[CB];
      assign sel[g] = sel_of(route_q, g);
      assign selected_req[g] = req_in[g][sel[g]];

      drm_chan u_chan (
        .mclk(mclk),
        .rst_n(rst_n),
        .fsm_clear(fsm_clear[g]),
        .request_enable(peripheral_request_enable_q[g]),
        .selected_request(selected_req[g]),
        .engine_done(engine_done[g]),
        .start_q(ch_start[g]),
        .ack_q(ch_ack[g]),
        .idle_q(ch_idle[g])
      );

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ack_q[g] <= 16'h0000;
        end else begin
          ack_q[g] <= ch_ack[g] ? one_hot(sel[g]) : 16'h0000;
        end
      end
    end
  endgenerate

  // Clear bits and reserved bits always read back as zero
  assign route_rd = route_q;
  assign rd_mux = (a_off == DRM_ROUTE_OFF) ? route_rd :
                  (a_off == DRM_ENABLE_OFF) ? {28'h0000000, peripheral_request_enable_q} :
                  (a_off == DRM_STATUS_OFF) ? {28'h0000000, ch_idle} :
                  32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      route_q <= DRM_ROUTE_RST;
      peripheral_request_enable_q <= DRM_ENABLE_RST;
    end else begin
      if (route_wr) begin
        route_q <= route_wdata;
      end
      if (enable_wr) begin
        peripheral_request_enable_q <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      wr_pend_q <= wr_go;
      wr_addr_q <= a_off;
      hreadyout_q <= 1'b1;
      if (rd_go) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign channel_start = ch_start;
  assign channel_idle = ch_idle;
  assign peripheral_dma_ack_ch0 = ack_q[0];
  assign peripheral_dma_ack_ch1 = ack_q[1];
  assign peripheral_dma_ack_ch2 = ack_q[2];
  assign peripheral_dma_ack_ch3 = ack_q[3];
endmodule
`default_nettype wire

// file: dv/drm_checker.sv
/* Port checker for drm_top: channel 0 start, idle and acknowledge pulses, and
   zero channel 0 clear and reserved bits (31:28) on routing register reads.
   Assumes it is bound into drm_top and sees only its ports. */
`default_nettype none
module drm_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] peripheral_dma_request_ch0,
  input wire logic [15:0] peripheral_dma_ack_ch0,
  input wire logic [3:0] channel_start,
  input wire logic [3:0] channel_idle
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_start_busy: assert property (channel_start[0] |-> !channel_idle[0])
    else $error("start while idle");
  chk_start_cause: assert property (channel_start[0] |->
    $past(channel_idle[0] && |peripheral_dma_request_ch0))
    else $error("start without cause");
  chk_start_pulse: assert property (channel_start[0] |=> !channel_start[0])
    else $error("start too long");
  chk_idle_fall: assert property ($fell(channel_idle[0]) |-> channel_start[0])
    else $error("idle fell alone");
  chk_ack_onehot: assert property ($onehot0(peripheral_dma_ack_ch0))
    else $error("ack not one-hot");
  chk_ack_pulse: assert property (|peripheral_dma_ack_ch0 |=> !peripheral_dma_ack_ch0)
    else $error("ack too long");
  chk_ack_after: assert property (|peripheral_dma_ack_ch0 |->
    channel_idle[0] && !$past(channel_idle[0]))
    else $error("ack outside transfer");
  chk_rsvd_read: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr[11:0] == 12'h0 |=> hrdata[31:28] == 4'h0)
    else $error("reserved bits set");
endmodule
bind drm_top drm_checker i_drm_checker(.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .peripheral_dma_request_ch0, .peripheral_dma_ack_ch0, .channel_start,
  .channel_idle);
`default_nettype wire

// file: dv/drm_periph.sv
/* Requesters of one channel: the selected peripheral raises its line when
   wanted, the others may chatter on theirs.
   Assumes the bench sets want, the selected line index and the chatter mask. */
`default_nettype none
module drm_periph (
  input wire logic want,
  input wire logic [3:0] idx,
  input wire logic [15:0] noise,
  output logic [15:0] req
);
  wire logic [15:0] line;
  assign line = 16'h0001 << idx;
  // Chatter never touches the selected line, so only want can start the channel
  assign req = (want ? line : 16'h0000) | (noise & ~line);
endmodule
`default_nettype wire

// file: dv/test_dma_request_routing_matrix.sv
/* Bench for drm_top: AHB-Lite master tasks, one requester model per channel,
   a queue of expected acknowledges and a watchdog.
   Assumes the package, design, drm_periph and drm_checker are compiled with it. */
`default_nettype none
module test_dma_request_routing_matrix;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, hrdy, hresp;
  logic [1:0] htrans = 0;
  logic [3:0] want = 0, done = 0, start, idle;
  logic [3:0] idx [4] = '{default: 4'h0};
  logic [15:0] noise [4] = '{default: 16'h0};
  wire logic [15:0] req [4];
  wire logic [15:0] ack [4];
  wire logic [63:0] acks;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, v, d;
  logic [63:0] q[$];
  int num_errors = 0, checks = 0, sh;
  assign acks = {ack[3], ack[2], ack[1], ack[0]};
  drm_top i_drm_top(.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp, .peripheral_dma_request_ch0(req[0]),
    .peripheral_dma_request_ch1(req[1]), .peripheral_dma_request_ch2(req[2]),
    .peripheral_dma_request_ch3(req[3]), .engine_done(done),
    .peripheral_dma_ack_ch0(ack[0]), .peripheral_dma_ack_ch1(ack[1]),
    .peripheral_dma_ack_ch2(ack[2]), .peripheral_dma_ack_ch3(ack[3]),
    .channel_start(start), .channel_idle(idle));
  for (genvar k = 0; k < 4; k++) begin : g_periph
    drm_periph i_drm_periph(.want(want[k]), .idx(idx[k]), .noise(noise[k]), .req(req[k]));
  end
  initial forever #25 mclk = ~mclk;
  // About 1100 cycles are needed; the limit allows 6000
  initial begin
    #300000;
    num_errors++;
    end_of_test;
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_ack(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    r = hrdata;
    cmp({31'h0, hresp}, 32'h0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    cmp(r, e);
  endtask
  // Waits for the start pulse of channel c alone, then drops want on every channel
  task wstart(input int c);
    repeat (20) begin
      @(negedge mclk);
      if (start[c]) break;
    end
    cmp({28'h0, start}, 32'h1 << c);
    @(posedge mclk);
    want <= 4'h0;
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (rst_n && acks !== 64'h0) begin
      cmp_ack(acks, q.size() ? q.pop_front() : 64'h0);
    end
  end
  initial begin
    void'($urandom(32'he43ba3c6));
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rd(0, 0);
    rd(4, 0);
    rd(8, 32'hf);
    bus(1, 0, 32'hffff_ffff);
    rd(0, 32'h0f0f_0f0f);
    rd(12'hc, 0);
    bus(1, 4, 32'hf);
    rd(4, 32'hf);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      for (int c = 0; c < 4; c++) begin
        v = $urandom;
        sh = 24 - 8 * c;
        // Every clear bit is set, as every selector may change
        d = ((v | 32'h8080_8080) & ~(32'hf << sh)) | ({28'h0, i[3:0]} << sh);
        idx[c] <= i[3:0];
        bus(1, 0, d);
        rd(0, d & 32'h0f0f_0f0f);
        noise[c] <= v[15:0];
        repeat (4) @(negedge mclk);
        cmp({28'h0, idle}, 32'hf);
        @(posedge mclk);
        want[c] <= 1'b1;
        wstart(c);
        q.push_back(64'h1 << (16 * c + i));
        repeat (v[25:24]) @(posedge mclk);
        done <= 4'hf;
        @(posedge mclk);
        done <= 4'h0;
        noise[c] <= 16'h0;
        repeat (3) @(posedge mclk);
      end
    end
    $display("channel test done");
    idx[0] <= 4'h7;
    bus(1, 0, 32'h8780_8080);
    bus(1, 4, 32'he);
    want[0] <= 1'b1;
    repeat (4) @(negedge mclk);
    cmp({28'h0, idle}, 32'hf);
    @(posedge mclk);
    bus(1, 4, 32'hf);
    wstart(0);
    rd(8, 32'he);
    bus(1, 0, 32'h8580_8080);
    @(negedge mclk);
    cmp({28'h0, idle}, 32'hf);
    @(posedge mclk);
    done <= 4'h1;
    @(posedge mclk);
    done <= 4'h0;
    rd(0, 32'h0500_0000);
    repeat (3) @(posedge mclk);
    $display("clear test done");
    idx[0] <= 4'h5;
    want[0] <= 1'b1;
    wstart(0);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(0, 0);
    rd(4, 0);
    rd(8, 32'hf);
    repeat (3) @(posedge mclk);
    cmp(q.size(), 32'h0);
    $display("reset test done");
    end_of_test;
  end
endmodule
`default_nettype wire
